// [bench/fsps_flash_model.sv]
// Flash array model on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module fsps_flash_model #(
  parameter int WORD_BITS = 4,
  parameter int PAGE_BITS = 5
) (
  input wire logic aclk,
  input wire logic flash_we,
  input wire logic flash_erase,
  input wire logic [PAGE_BITS-1:0] flash_page,
  input wire logic [15:0] flash_wdata,
  input wire logic [WORD_BITS-1:0] flash_word,
  output logic [7:0] wr_count,
  output logic [7:0] viol_count
);
  logic [15:0] mem [2**PAGE_BITS][2**WORD_BITS];
  logic [PAGE_BITS-1:0] erased_page;
  initial begin
    wr_count = 8'h00;
    viol_count = 8'h00;
    erased_page = '0;
    foreach (mem[p, w]) mem[p][w] = 16'h0000;
  end
  always @(posedge aclk) begin
    if (flash_erase === 1'b1) begin
      erased_page = flash_page;
      for (int w = 0; w < 2**WORD_BITS; w++) mem[flash_page][w] = 16'hFFFF;
    end
    if (flash_we === 1'b1) begin
      if (mem[flash_page][flash_word] !== 16'hFFFF) viol_count++;
      if (flash_page !== erased_page) viol_count++;
      mem[flash_page][flash_word] = flash_wdata;
      wr_count++;
    end
  end
endmodule : fsps_flash_model
`default_nettype wire

// [bench/fsps_sequencer_test.sv]
// Register-level bench for the self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fsps_params.svh"
module fsps_sequencer_test;
  localparam int PROG = 40;
  localparam logic [4:0] PG_A = 5'h13;
  localparam logic [4:0] PG_B = 5'h1F;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp, last_resp;
  logic eeprom_busy = 1'b0;
  logic core_halt, flash_we, flash_erase;
  logic [4:0] flash_page, er_page;
  logic [15:0] flash_wdata;
  logic [3:0] flash_word;
  logic [7:0] wr_count, viol_count;
  logic [31:0] v;
  int n_ops = 0, cur = 0, last_len = 0, fail_count = 0, checks = 0;
  always #12.5 aclk = ~aclk;
  fsps_sequencer #(.PROG_CYCLES(PROG)) u_fsps_sequencer (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .eeprom_busy(eeprom_busy), .core_halt(core_halt), .flash_we(flash_we),
    .flash_erase(flash_erase), .flash_page(flash_page),
    .flash_wdata(flash_wdata), .flash_word(flash_word));
  fsps_flash_model u_fsps_flash_model (.aclk(aclk), .flash_we(flash_we),
    .flash_erase(flash_erase), .flash_page(flash_page),
    .flash_wdata(flash_wdata), .flash_word(flash_word),
    .wr_count(wr_count), .viol_count(viol_count));
  // Halt episodes and their lengths
  always @(negedge aclk) begin
    if (flash_erase === 1'b1) er_page = flash_page;
    if (core_halt === 1'b1) cur++;
    else if (cur != 0) begin
      last_len = cur;
      n_ops++;
      cur = 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("fail_count %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      done = (bvalid === 1'b1);
      last_resp = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_hit, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ar_hit = arvalid & arready;
      done = (rvalid === 1'b1);
      d = rdata;
      last_resp = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
    end
  endtask : rd
  task automatic store_program_instruction(input logic [7:0] c);
    wr(`FSPS_CTRL_ADDR, {24'h0, c});
    wr(`FSPS_STAT_ADDR, 32'h0);
  endtask : store_program_instruction
  task automatic setptr(input logic [4:0] pg, input logic [3:0] w,
                        input logic lsb);
    wr(`FSPS_ADDR_ADDR, {16'h0, 6'h0, pg, w, lsb});
  endtask : setptr
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((core_halt !== 1'b0 || n < 8) && n < 300);
    repeat (24) @(posedge aclk);
  endtask : settle
  // one buffer word is loaded per call, at most once per fill
  task automatic load(input logic [4:0] pg, input logic [3:0] w,
                      input logic [15:0] d);
    logic [31:0] st;
    // poll EEPROM busy before writing control
    do rd(`FSPS_STAT_ADDR, st); while (st[1] !== 1'b0);
    setptr(pg, w, 1'b1);
    wr(`FSPS_DATA_ADDR, {16'h0, d});
    store_program_instruction(8'h01);
  endtask : load
  task automatic page_cycle(input logic [4:0] pg);
    // non-page pointer bits zero for write
    setptr(pg, 4'h0, 1'b0);
    store_program_instruction(8'h03);
    settle();
    store_program_instruction(8'h05);
    settle();
  endtask : page_cycle
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
  initial begin
    logic [15:0] ptrs [3] = '{16'h0001, 16'h0000, 16'h0003};
    logic [7:0] exps [3] = '{8'hFF, 8'h5A, 8'hFE};
    logic [7:0] bad [5] = '{8'h07, 8'h0F, 8'h1F, 8'h15, 8'h0B};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`FSPS_CTRL_ADDR, v);
    check(v, 32'h0);
    rd(`FSPS_STAT_ADDR, v);
    check(v[0], 1'b0);
    store_program_instruction(8'h03);
    settle();
    check(n_ops, 0);
    wr(`FSPS_FUSE_ADDR, 32'h00FFFE5A);
    rd(`FSPS_STAT_ADDR, v);
    check(v[0], 1'b1);
    rd(8'h1C, v);
    check(last_resp, 2'b10);
    for (int i = 0; i < 3; i++) begin
      wr(`FSPS_ADDR_ADDR, {16'h0, ptrs[i]});
      wr(`FSPS_CTRL_ADDR, 32'h09);
      wr(`FSPS_LPM_ADDR, 32'h0);
      rd(`FSPS_RDATA_ADDR, v);
      check(v[7:0], exps[i]);
    end
    load(PG_A, 4'hF, 16'hA5C3);
    load(PG_A, 4'h0, 16'h0F1E);
    load(PG_A, 4'h6, 16'h7E81);
    setptr(PG_A, 4'hA, 1'b1);
    store_program_instruction(8'h03);
    rd(`FSPS_CTRL_ADDR, v);
    check(v[4:0], 5'h03);
    settle();
    check(n_ops, 1);
    check(last_len >= PROG, 1'b1);
    check(er_page, PG_A);
    rd(`FSPS_CTRL_ADDR, v);
    check(v, 32'h0);
    setptr(PG_A, 4'h0, 1'b0);
    wr(`FSPS_DATA_ADDR, 32'hFFFF);
    store_program_instruction(8'h05);
    settle();
    check(n_ops, 2);
    check(last_len >= PROG, 1'b1);
    check(wr_count, 8'd3);
    check(u_fsps_flash_model.mem[PG_A][15], 16'hA5C3);
    check(u_fsps_flash_model.mem[PG_A][0], 16'h0F1E);
    check(u_fsps_flash_model.mem[PG_A][6], 16'h7E81);
    check(u_fsps_flash_model.mem[PG_A][1], 16'hFFFF);
    page_cycle(PG_A);
    check(wr_count, 8'd3);
    setptr(PG_B, 4'h3, 1'b0);
    wr(`FSPS_DATA_ADDR, 32'h1234);
    wr(`FSPS_CTRL_ADDR, 32'h01);
    repeat (8) @(posedge aclk);
    rd(`FSPS_CTRL_ADDR, v);
    check(v, 32'h0);
    wr(`FSPS_STAT_ADDR, 32'h0);
    page_cycle(PG_B);
    check(wr_count, 8'd3);
    foreach (bad[i]) store_program_instruction(bad[i]);
    settle();
    rd(`FSPS_CTRL_ADDR, v);
    check(v, 32'h0);
    check(n_ops, 6);
    load(PG_B, 4'h2, 16'hBEEF);
    store_program_instruction(8'h11);
    page_cycle(PG_B);
    check(wr_count, 8'd3);
    load(PG_B, 4'h4, 16'hCAFE);
    eeprom_busy <= 1'b1;
    repeat (4) @(posedge aclk);
    eeprom_busy <= 1'b0;
    page_cycle(PG_B);
    check(wr_count, 8'd3);
    eeprom_busy <= 1'b1;
    rd(`FSPS_STAT_ADDR, v);
    check(v[1], 1'b1);
    store_program_instruction(8'h03);
    settle();
    check(n_ops, 10);
    eeprom_busy <= 1'b0;
    load(PG_B, 4'h7, 16'h1357);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`FSPS_FUSE_ADDR, 32'h00FFFE5A);
    page_cycle(PG_B);
    check(wr_count, 8'd3);
    check(viol_count, 8'd0);
    complete_run();
  end
endmodule : fsps_sequencer_test
`default_nettype wire

// [core/fsps_buffer.sv]
// Temporary page buffer with per-word valid bits and registered read data
`timescale 1ns/10ps
`default_nettype none
module fsps_buffer #(
  parameter int WORDS = 16
) (
  input wire logic aclk,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [$clog2(WORDS)-1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [WORDS-1:0] loaded
);
  logic [15:0] mem [WORDS];
  initial begin
    if (WORDS < 2) begin
      $error("fsps_buffer needs at least two words");
    end
  end
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= loaded[rd_idx] ? mem[rd_idx] : 16'hFFFF;
  end
  always_ff @(posedge aclk) begin
    if (clear) begin
      loaded <= '0;
    end else if (wr_en) begin
      loaded[wr_idx] <= 1'b1;
    end
  end
endmodule : fsps_buffer
`default_nettype wire

// [core/fsps_params.svh]
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH
`define FSPS_CTRL_ADDR 8'h00
`define FSPS_ADDR_ADDR 8'h04
`define FSPS_DATA_ADDR 8'h08
`define FSPS_STAT_ADDR 8'h0C
`define FSPS_LPM_ADDR 8'h10
`define FSPS_RDATA_ADDR 8'h14
`define FSPS_FUSE_ADDR 8'h18
`define FSPS_CTRL_RESET 5'h00
`define FSPS_CMD_LOAD 5'h01
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_READFL 5'h09
`define FSPS_CMD_CLEAR 5'h11
`define FSPS_SPM_WINDOW 3'h4
`define FSPS_LPM_WINDOW 3'h3
`define FSPS_PROG_MIN_NS 3700000
`define FSPS_PROG_MAX_NS 4500000
`define FSPS_CLK_NS 25
`define FSPS_PROG_CYCLES ((`FSPS_PROG_MIN_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS)
`define FSPS_ZPTR_LOCK 16'h0001
`define FSPS_ZPTR_FLOW 16'h0000
`define FSPS_ZPTR_FHIGH 16'h0003
`define FSPS_FUSE_BIT 0
`endif

// [core/fsps_pkg.sv]
// Types shared by the flash self-programming sequencer
package fsps_pkg;
  typedef enum logic [2:0] {
    st_idle, st_armed, st_read_arm, st_erase, st_write
  } fsps_state_e;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } fsps_rd_s;
endpackage : fsps_pkg

// [core/fsps_sequencer.sv]
// Flash self-programming sequencer with an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "fsps_params.svh"
module fsps_sequencer #(
  parameter int WORD_BITS = 4,
  parameter int PAGE_BITS = 5,
  parameter int PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_busy,
  output logic core_halt,
  output logic flash_we,
  output logic flash_erase,
  output logic [PAGE_BITS-1:0] flash_page,
  output logic [15:0] flash_wdata,
  output logic [WORD_BITS-1:0] flash_word
);
  localparam int WORDS = 1 << WORD_BITS;
  initial begin
    if (WORD_BITS + PAGE_BITS + 1 > 16 || PROG_CYCLES < 2) begin
      $error("fsps_sequencer parameters out of range");
    end
  end

  fsps_pkg::fsps_state_e state;
  logic [4:0] ctrl;
  logic [15:0] zptr;
  logic [15:0] data_pair;
  logic [7:0] lock_bits, fuse_low, fuse_high;
  logic [2:0] win_cnt;
  logic [22:0] prog_cnt;
  logic [WORD_BITS-1:0] wr_ptr;
  logic [7:0] lpm_data;
  logic loading;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Write channel capture in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire [7:0] wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb_q : s_axi_wstrb;
  wire wr_fire = have_aw && have_w && !s_axi_bvalid;
  wire wr_ok = wr_addr == `FSPS_CTRL_ADDR || wr_addr == `FSPS_ADDR_ADDR ||
    wr_addr == `FSPS_DATA_ADDR || wr_addr == `FSPS_LPM_ADDR ||
    wr_addr == `FSPS_FUSE_ADDR;
  wire ctrl_wr = wr_fire && wr_addr == `FSPS_CTRL_ADDR && wr_strb[0];
  wire zptr_wr = wr_fire && wr_addr == `FSPS_ADDR_ADDR;
  wire data_wr = wr_fire && wr_addr == `FSPS_DATA_ADDR;
  wire fuse_wr = wr_fire && wr_addr == `FSPS_FUSE_ADDR;
  // Store-program issue is a write to the store strobe, load-program a write to the LPM offset
  wire spm_issue = wr_fire && wr_addr == `FSPS_STAT_ADDR && wr_strb[0];
  wire lpm_issue = wr_fire && wr_addr == `FSPS_LPM_ADDR && wr_strb[0];

  wire [4:0] pat = wr_data[4:0];
  wire pat_ok = pat == `FSPS_CMD_LOAD || pat == `FSPS_CMD_ERASE ||
    pat == `FSPS_CMD_WRITE || pat == `FSPS_CMD_READFL ||
    pat == `FSPS_CMD_CLEAR;
  // EEPROM blocks programming and fuse reads
  wire ctrl_accept = ctrl_wr && pat_ok && !eeprom_busy &&
    (state == fsps_pkg::st_idle || state == fsps_pkg::st_armed ||
     state == fsps_pkg::st_read_arm);
  // Fuse must be programmed to zero
  wire selfprog_ok = !fuse_high[`FSPS_FUSE_BIT];
  // Only an armed window makes a store act
  wire spm_act = spm_issue && state == fsps_pkg::st_armed && selfprog_ok &&
    !eeprom_busy;
  wire do_load = spm_act && ctrl == `FSPS_CMD_LOAD;
  wire do_erase = spm_act && ctrl == `FSPS_CMD_ERASE;
  wire do_write = spm_act && ctrl == `FSPS_CMD_WRITE;
  // Pointer split: byte bit, word field, page field
  wire [WORD_BITS-1:0] z_word = zptr[WORD_BITS:1];
  wire [PAGE_BITS-1:0] z_page = zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  wire buf_clear = !aresetn || (ctrl_accept && pat == `FSPS_CMD_CLEAR) ||
    (state == fsps_pkg::st_write && prog_cnt == 23'h0) ||
    (loading && eeprom_busy);
  wire busy = state == fsps_pkg::st_erase || state == fsps_pkg::st_write;
  wire win_last = win_cnt == 3'h1;
  wire [15:0] buf_rdata;
  wire [WORDS-1:0] buf_loaded;

  // Any order, word field picks slot
  fsps_buffer #(
    .WORDS(WORDS)
  ) u_buf (
    .aclk(aclk),
    .clear(buf_clear),
    .wr_en(do_load),
    .wr_idx(z_word),
    .wr_data(data_pair),
    .rd_idx(wr_ptr),
    .rd_data(buf_rdata),
    .loaded(buf_loaded)
  );

  // Load-program read, byte select from pointer bit 0
  wire [7:0] flash_byte = zptr[0] ? buf_rdata[15:8] : buf_rdata[7:0];
  // Fuse and lock selection by pointer
  wire [7:0] fl_byte = zptr == `FSPS_ZPTR_LOCK ? lock_bits :
    zptr == `FSPS_ZPTR_FLOW ? fuse_low :
    zptr == `FSPS_ZPTR_FHIGH ? fuse_high : 8'h00;
  wire [7:0] next_lpm = (state == fsps_pkg::st_read_arm && !eeprom_busy) ?
    fl_byte : flash_byte;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      aw_held <= have_aw && !wr_fire;
      w_held <= have_w && !wr_fire;
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready <= !have_w && !s_axi_bvalid && !s_axi_wready;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ok || spm_issue) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zptr <= 16'h0;
      data_pair <= 16'h0;
      lock_bits <= 8'hFF;
      fuse_low <= 8'hFF;
      fuse_high <= 8'hFF;
      lpm_data <= 8'h00;
    end else begin
      if (zptr_wr) zptr <= wr_data[15:0];
      if (data_wr) data_pair <= wr_data[15:0];
      if (fuse_wr) begin
        fuse_low <= wr_data[7:0];
        fuse_high <= wr_data[15:8];
        lock_bits <= wr_data[23:16];
      end
      if (lpm_issue) lpm_data <= next_lpm;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= fsps_pkg::st_idle;
      ctrl <= `FSPS_CTRL_RESET;
      win_cnt <= 3'h0;
      prog_cnt <= 23'h0;
      loading <= 1'b0;
    end else begin
      unique case (state)
        fsps_pkg::st_idle, fsps_pkg::st_armed, fsps_pkg::st_read_arm: begin
          if (do_erase) begin
            state <= fsps_pkg::st_erase;
            prog_cnt <= 23'(PROG_CYCLES - 1);
          end else if (do_write) begin
            state <= fsps_pkg::st_write;
            prog_cnt <= 23'(PROG_CYCLES - 1);
          end else if (ctrl_accept && pat == `FSPS_CMD_READFL) begin
            state <= fsps_pkg::st_read_arm;
            ctrl <= pat;
            win_cnt <= `FSPS_LPM_WINDOW;
          end else if (ctrl_accept && pat != `FSPS_CMD_CLEAR) begin
            state <= fsps_pkg::st_armed;
            ctrl <= pat;
            win_cnt <= `FSPS_SPM_WINDOW;
          end else if (spm_act || win_last ||
                       (state == fsps_pkg::st_read_arm && lpm_issue)) begin
            state <= fsps_pkg::st_idle;
            ctrl <= `FSPS_CTRL_RESET;
            win_cnt <= 3'h0;
          end else if (win_cnt != 3'h0) begin
            win_cnt <= win_cnt - 3'h1;
          end
          // Loading tracked until a page write or EEPROM busy
          if (do_load) loading <= 1'b1;
        end
        fsps_pkg::st_erase, fsps_pkg::st_write: begin
          if (prog_cnt == 23'h0) begin
            state <= fsps_pkg::st_idle;
            ctrl <= `FSPS_CTRL_RESET;
            if (state == fsps_pkg::st_write) loading <= 1'b0;
          end else begin
            prog_cnt <= prog_cnt - 23'h1;
          end
        end
      endcase
      if (loading && eeprom_busy) loading <= 1'b0;
    end
  end

  // Flash programming port, word pointer walks the buffer during a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      flash_we <= 1'b0;
      flash_erase <= 1'b0;
      flash_page <= '0;
      flash_word <= '0;
      flash_wdata <= 16'h0;
      core_halt <= 1'b0;
    end else begin
      core_halt <= busy ? prog_cnt != 23'h0 : (do_erase || do_write);
      // Page taken from page field only
      if (do_erase || do_write) flash_page <= z_page;
      flash_erase <= do_erase;
      if (state == fsps_pkg::st_write && prog_cnt <= 23'(WORDS + 1) &&
          prog_cnt != 23'h0) begin
        wr_ptr <= wr_ptr + 1'b1;
        flash_we <= prog_cnt <= 23'(WORDS) && buf_loaded[flash_word + 1'b1];
        flash_word <= wr_ptr - 1'b1;
        flash_wdata <= buf_rdata;
      end else begin
        wr_ptr <= '0;
        flash_we <= 1'b0;
      end
    end
  end

  // Read channel
  wire [31:0] rd_word =
    s_axi_araddr == `FSPS_CTRL_ADDR ?
      {27'h0, ctrl & {5{state != fsps_pkg::st_idle}}} :
    s_axi_araddr == `FSPS_ADDR_ADDR ? {16'h0, zptr} :
    s_axi_araddr == `FSPS_DATA_ADDR ? {16'h0, data_pair} :
    s_axi_araddr == `FSPS_STAT_ADDR ?
      {24'h0, 4'h0, loading, busy, eeprom_busy, selfprog_ok} :
    s_axi_araddr == `FSPS_RDATA_ADDR ? {24'h0, lpm_data} :
    s_axi_araddr == `FSPS_FUSE_ADDR ? {8'h0, lock_bits, fuse_high, fuse_low} :
    32'h0;
  wire rd_ok = s_axi_araddr <= `FSPS_FUSE_ADDR && s_axi_araddr[1:0] == 2'h0 &&
    s_axi_araddr != `FSPS_LPM_ADDR;
  fsps_pkg::fsps_rd_s next_rd;
  assign next_rd = '{resp: rd_ok ? 2'h0 : 2'h2, data: rd_word};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rd.data;
        s_axi_rresp <= next_rd.resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  int unsigned halt_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_halt) halt_cnt <= 0;
    else halt_cnt <= halt_cnt + 1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence erase_cmd_s;
    do_erase;
  endsequence
  erase_halt_a: assert property (erase_cmd_s |=> core_halt [*8])
    else $error("halt missing in erase");
  write_halt_a: assert property (
    do_write |=> core_halt && state == fsps_pkg::st_write)
    else $error("halt missing in write");
  fuse_gate_a: assert property (
    spm_issue && !selfprog_ok |=> state != fsps_pkg::st_erase || $past(busy))
    else $error("store acted with fuse unprogrammed");
  window_end_a: assert property (
    ctrl_accept && pat == `FSPS_CMD_LOAD && !spm_issue ##1 !spm_issue [*4]
    |=> state == fsps_pkg::st_idle) else $error("window did not close");
  late_store_a: assert property (
    spm_issue && state == fsps_pkg::st_idle |=> !busy && $stable(buf_loaded))
    else $error("late store had effect");
  bad_pat_a: assert property (
    ctrl_wr && !pat_ok && state == fsps_pkg::st_idle |=>
    state == fsps_pkg::st_idle) else $error("illegal pattern acted on");
  eeprom_block_a: assert property (eeprom_busy && spm_issue |=>
    !$rose(busy)) else $error("store during eeprom");
  load_word_a: assert property (do_load |=> buf_loaded[$past(z_word)])
    else $error("load word missing");
  prog_time_a: assert property (
    $fell(core_halt) |-> $past(halt_cnt) + 2 >= PROG_CYCLES)
    else $error("program time too short");
endmodule : fsps_sequencer
`default_nettype wire
